// ==== rtl/dac_input_latch_sleep.sv ====
`timescale 1ns/1ps
// Contract
// (RULE1) one eight-bit sample word plus one clock, all bits presented together
// (RULE2) straight binary, bit 7 most significant, bit 0 least significant
// (RULE3) edge-triggered capture, output updated after each rising clock edge
// (RULE4) new sample accepted on every clock cycle at full rate; here only on edges with clkEn high
// (RULE5) primary weight equals latched code over 256 of full scale
// (RULE6) complementary weight equals 255 minus code over 256
// (RULE7) undriven sleep input reads as deasserted, converter stays enabled
// (RULE8) sleep high turns both outputs off, low resumes conversion
// (RULE9) code is zero until first edge, held unchanged during sleep
module dac_input_latch_sleep (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   input  wire logic       clkEn,
   // sample word
   input  wire logic [7:0] sampleWord,
   // power control pin, undriven reads low
   input  wire logic       sleepPin,
   // converter outputs, numerators over 256 of full scale
   output logic      [7:0] latchedCode,
   output logic      [8:0] weightPrimary,
   output logic      [8:0] weightComp,
   output logic            outputsOn
);
   // ----------------------------------------
   // sleep synchroniser
   // ----------------------------------------
   logic sleepSync;

   // sleep is a slow pin, so two flops of latency are harmless
   sync_two_ff #(
      .WIDTH (1)
   ) u_sleep_sync (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .clkEn   (clkEn),
      .asyncIn (sleepPin),
      .syncOut (sleepSync)
   );

   // sync output leads outputsOn by exactly one enabled edge
   a_sync_sleep: assert property ( // RULE8
      @(posedge clk_sys) disable iff (!resetn)
      (clkEn && sleepSync) |=> !outputsOn)
      else $error("sleep did not turn outputs off");

   a_sync_wake: assert property ( // RULE8
      @(posedge clk_sys) disable iff (!resetn)
      (clkEn && !sleepSync) |=> outputsOn)
      else $error("wake did not turn outputs on");

   a_sync_freeze: assert property ( // RULE8
      @(posedge clk_sys) disable iff (!resetn)
      !clkEn |=> $stable(sleepSync))
      else $error("sleep sync moved with clock enable low");

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] code;
      logic [8:0] wPri;
      logic [8:0] wComp;
      logic       on;
   } latch_s;

   latch_s state_reg;
   latch_s state_next;
   logic   awake;

   // unsigned numerator of an all-ones code, used by the checks
   logic [8:0] fullWeight;
   assign fullWeight = {1'b0, dac_latch_pkg::CODE_MAX};

   // a pull-down pin floats to zero, so only a driven one sleeps
   assign awake = ~sleepSync; // RULE7

   always_comb begin
      state_next = state_reg;
      if (clkEn) begin
         state_next.on = awake; // RULE8
         if (awake) begin
            // word taken whole on every awake edge with clkEn high, held when clkEn is low or during sleep
            state_next.code  = sampleWord; // RULE1 RULE3 RULE4
            // bit 7 weighs 128, plain binary
            state_next.wPri  = {1'b0, sampleWord}; // RULE2 RULE5
            state_next.wComp = {1'b0,
                                dac_latch_pkg::CODE_MAX - sampleWord}; // RULE6
         end else begin
            // code kept during sleep; the wake-up edge loads a fresh sample
            state_next.wPri  = dac_latch_pkg::WEIGHT_OFF; // RULE8 RULE9
            state_next.wComp = dac_latch_pkg::WEIGHT_OFF; // RULE8
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_reg.code  <= dac_latch_pkg::CODE_RESET; // RULE9
         state_reg.wPri  <= dac_latch_pkg::WEIGHT_OFF;
         state_reg.wComp <= {1'b0, dac_latch_pkg::CODE_MAX};
         state_reg.on    <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign latchedCode   = state_reg.code;
   assign weightPrimary = state_reg.wPri;
   assign weightComp    = state_reg.wComp;
   assign outputsOn     = state_reg.on;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_capture_word: assert property ( // RULE3
      @(posedge clk_sys) disable iff (!resetn)
      (clkEn && !sleepSync) |=> latchedCode == $past(sampleWord))
      else $error("latched code does not follow sample word");

   a_every_cycle: assert property ( // RULE4
      @(posedge clk_sys) disable iff (!resetn)
      (clkEn && !sleepSync) [*2] |=> latchedCode == $past(sampleWord))
      else $error("back to back sample lost");

   a_primary_weight: assert property ( // RULE5
      @(posedge clk_sys) disable iff (!resetn)
      outputsOn |-> weightPrimary == {1'b0, latchedCode})
      else $error("primary weight wrong");

   a_comp_weight: assert property ( // RULE6
      @(posedge clk_sys) disable iff (!resetn)
      outputsOn |-> weightPrimary + weightComp == 9'h0ff)
      else $error("complementary weight wrong");

   a_msb_weight: assert property ( // RULE2
      @(posedge clk_sys) disable iff (!resetn)
      (outputsOn && latchedCode[7]) |-> weightPrimary >= 9'h080)
      else $error("msb not most significant");

   a_sleep_off: assert property ( // RULE8
      @(posedge clk_sys) disable iff (!resetn)
      (clkEn && sleepPin) [*3] |=> !outputsOn && weightPrimary == 9'h000
      && weightComp == 9'h000)
      else $error("outputs not off in sleep");

   a_sleep_hold: assert property ( // RULE9
      @(posedge clk_sys) disable iff (!resetn)
      !outputsOn && clkEn && sleepSync |=> $stable(latchedCode))
      else $error("code changed during sleep");

   a_low_awake: assert property ( // RULE7
      @(posedge clk_sys) disable iff (!resetn)
      (clkEn && !sleepPin) [*3] |=> outputsOn)
      else $error("low sleep pin did not enable");

   a_freeze: assert property ( // RULE1
      @(posedge clk_sys) disable iff (!resetn)
      !clkEn |=> $stable(latchedCode) && $stable(outputsOn))
      else $error("state moved with clock enable low");

   a_freeze_weights: assert property ( // RULE1
      @(posedge clk_sys) disable iff (!resetn)
      !clkEn |=> $stable(weightPrimary) && $stable(weightComp))
      else $error("weights moved with clock enable low");

   // ----------------------------------------
   // reset checks
   // ----------------------------------------
   // the converter has no reset input, so this is only our power-on state;
   // two low edges let the asynchronous clear land before sampling
   a_reset_code: assert property ( // RULE9
      @(posedge clk_sys)
      !resetn [*2] |-> latchedCode == dac_latch_pkg::CODE_RESET
      && outputsOn)
      else $error("code not zero out of reset");

   a_reset_weights: assert property ( // RULE6
      @(posedge clk_sys)
      !resetn [*2] |-> weightPrimary == dac_latch_pkg::WEIGHT_OFF
      && weightComp == fullWeight)
      else $error("weights wrong out of reset");

   // ----------------------------------------
   // capture and weight checks
   // ----------------------------------------
   a_word_whole: assert property ( // RULE1
      @(posedge clk_sys) disable iff (!resetn)
      (clkEn && !sleepSync) |=> weightPrimary[7:0] == $past(sampleWord))
      else $error("primary weight not the whole sample word");

   a_comp_capture: assert property ( // RULE6
      @(posedge clk_sys) disable iff (!resetn)
      (clkEn && !sleepSync) |=>
      weightComp == fullWeight - {1'b0, $past(sampleWord)})
      else $error("complementary weight does not track sample");

   a_lsb_side: assert property ( // RULE2
      @(posedge clk_sys) disable iff (!resetn)
      (outputsOn && !latchedCode[7]) |-> weightPrimary < 9'h080)
      else $error("code below msb weighs too much");

   a_pri_full: assert property ( // RULE5
      @(posedge clk_sys) disable iff (!resetn)
      (outputsOn && latchedCode == dac_latch_pkg::CODE_MAX)
      |-> weightPrimary == fullWeight)
      else $error("all ones code not near full scale");

   a_comp_empty: assert property ( // RULE6
      @(posedge clk_sys) disable iff (!resetn)
      (outputsOn && latchedCode == dac_latch_pkg::CODE_MAX)
      |-> weightComp == dac_latch_pkg::WEIGHT_OFF)
      else $error("complementary weight not empty at all ones");

   a_pri_empty: assert property ( // RULE5
      @(posedge clk_sys) disable iff (!resetn)
      (outputsOn && latchedCode == dac_latch_pkg::CODE_RESET)
      |-> weightPrimary == dac_latch_pkg::WEIGHT_OFF)
      else $error("zero code gives primary weight");

   // the ninth bit only exists to keep the arithmetic unsigned
   a_weight_range: assert property ( // RULE5
      @(posedge clk_sys) disable iff (!resetn)
      weightPrimary <= fullWeight && weightComp <= fullWeight)
      else $error("weight above full scale numerator");

   // ----------------------------------------
   // sleep output checks
   // ----------------------------------------
   a_off_zero: assert property ( // RULE8
      @(posedge clk_sys) disable iff (!resetn)
      !outputsOn |-> weightPrimary == dac_latch_pkg::WEIGHT_OFF
      && weightComp == dac_latch_pkg::WEIGHT_OFF)
      else $error("weights present while outputs off");

   a_sleep_code: assert property ( // RULE9
      @(posedge clk_sys) disable iff (!resetn)
      (clkEn && sleepSync) |=> $stable(latchedCode))
      else $error("code moved while sleep sampled");
endmodule

// ==== rtl/dac_latch_pkg.sv ====
package dac_latch_pkg;
   // ----------------------------------------
   // data path
   // ----------------------------------------
   localparam int            CODE_W     = 8;
   localparam int            WEIGHT_W   = 9;
   localparam int            FULL_DIV   = 256;
   localparam logic [7:0]    CODE_MAX   = 8'hff;
   localparam logic [7:0]    CODE_RESET = 8'h00;
   localparam logic [8:0]    WEIGHT_OFF = 9'h000;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int            CLK_MHZ    = 100;
   localparam int            MAX_MSPS   = 125;
   localparam int            SLEEP_SYNC = 2;
endpackage

// ==== rtl/sync_two_ff.sv ====
`timescale 1ns/1ps
module sync_two_ff #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             resetn,
   input  wire logic             clkEn,
   // data
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } sync_s;

   sync_s state_reg;
   sync_s state_next;

   always_comb begin
      state_next = state_reg;
      if (clkEn) begin
         state_next.stage1 = asyncIn;
         state_next.stage2 = state_reg.stage1;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign syncOut = state_reg.stage2;
endmodule

// ==== testbench/sample_source.sv ====
`timescale 1ns/1ps
// ----
// sample source
// ----
module sample_source (
   input  wire logic       clk_sys,
   input  wire logic [7:0] nextWord,
   output logic      [7:0] sampleWord
);
   // whole word moves at once, bit 7 msb
   always @(negedge clk_sys) sampleWord <= nextWord;
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic        clk_sys;
   logic        resetn;
   logic        clkEn;
   logic        sleepDrv;
   logic  [7:0] nextWord;
   logic  [7:0] sampleWord;
   logic  [7:0] latchedCode;
   logic  [8:0] weightPrimary;
   logic  [8:0] weightComp;
   logic        outputsOn;
   wire         sleepNet;
   logic [31:0] rng;
   logic  [7:0] mCode;
   logic        mS1;
   logic        mS2;
   logic        mOn;
   int          n_mismatch;
   int          n_tests;
   logic  [7:0] corner [5] = '{8'h00, 8'hff, 8'h80, 8'h01, 8'h7f};
   // undriven pin must rest low
   pulldown (sleepNet);
   assign sleepNet = sleepDrv ? 1'b1 : 1'bz;
   sample_source src (.clk_sys(clk_sys), .nextWord(nextWord),
      .sampleWord(sampleWord));
   dac_input_latch_sleep uut (.clk_sys(clk_sys), .resetn(resetn),
      .clkEn(clkEn), .sampleWord(sampleWord), .sleepPin(sleepNet),
      .latchedCode(latchedCode), .weightPrimary(weightPrimary),
      .weightComp(weightComp), .outputsOn(outputsOn));
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic logic [8:0] wgt(input logic [7:0] c, input logic on,
                                      input logic comp);
      if (!on) return 9'h000;
      return comp ? {1'b0, dac_latch_pkg::CODE_MAX} - {1'b0, c} : {1'b0, c};
   endfunction
   task automatic chk(input string nm, input logic [8:0] e,
                      input logic [8:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic summarize();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic expectAll();
      chk("code", {1'b0, mCode}, {1'b0, latchedCode});
      chk("primary", wgt(mCode, mOn, 1'b0), weightPrimary);
      chk("comp", wgt(mCode, mOn, 1'b1), weightComp);
      chk("on", {8'h00, mOn}, {8'h00, outputsOn});
   endtask
   // ----
   // one cycle: sleep seen after two sync edges
   // ----
   task automatic cyc(input logic [7:0] w, input logic sl, input logic en);
      nextWord = w;
      @(negedge clk_sys);
      sleepDrv = sl;
      clkEn = en;
      @(posedge clk_sys);
      if (en) begin
         if (!mS2) mCode = w;
         mOn = !mS2;
         mS2 = mS1;
         mS1 = sl;
      end
      #1;
      expectAll();
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      #20000;
      n_mismatch++;
      summarize();
   end
   initial begin
      {n_mismatch, n_tests} = '0;
      {clkEn, sleepDrv, resetn, nextWord} = 11'h000;
      {mCode, mS1, mS2, mOn} = 11'h001;
      rng = 32'h325d;
      repeat (3) @(negedge clk_sys);
      expectAll();
      resetn = 1'b1;
      foreach (corner[k]) cyc(corner[k], 1'b0, 1'b1);
      for (int i = 0; i < 120; i++) begin
         rng = xs(rng);
         cyc(rng[7:0], (i >= 40 && i < 60) || (i >= 90 && i < 95),
             rng[10:8] != 3'h0);
      end
      summarize();
   end
endmodule
